// >>> src/addsub_if.sv
`timescale 1ns/1ps

interface addsub_if;

  logic [31:0]         a;
  logic [31:0]         b;
  logic                sub;
  logic [1:0]          half_sub;
  logic                half_unsigned;
  sat_pkg::lane_width_t width;
  logic [31:0]         sum;
  logic                sat_any;

  modport unit
  (
    input  a,
    input  b,
    input  sub,
    input  half_sub,
    input  half_unsigned,
    input  width,
    output sum,
    output sat_any
  );

  modport user
  (
    output a,
    output b,
    output sub,
    output half_sub,
    output half_unsigned,
    output width,
    input  sum,
    input  sat_any
  );

endinterface

// >>> src/lane_sat_addsub.sv
`timescale 1ns/1ps

module lane_sat_addsub
(
  // operands and results
  addsub_if.unit lanes
);

  // ************************************************************
  // per-lane arithmetic
  // ************************************************************
  logic [31:0] byte_sum;
  logic [31:0] half_sum;
  logic [31:0] word_sum;
  logic [3:0]  byte_sat;
  logic [1:0]  half_sat;
  logic        word_sat;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_byte
      logic signed [8:0] xa;
      logic signed [8:0] xb;
      logic signed [8:0] r;
      assign xa = {lanes.a[8*i+7], lanes.a[8*i +: 8]};
      assign xb = {lanes.b[8*i+7], lanes.b[8*i +: 8]};
      assign r  = lanes.sub ? xa - xb : xa + xb;
      assign byte_sat[i] = (r > 9'sh07F) || (r < -9'sh080);
      assign byte_sum[8*i +: 8] = (r > 9'sh07F) ? 8'h7F :
                                  (r < -9'sh080) ? 8'h80 : r[7:0];
    end
    for (i = 0; i < 2; i++)
    begin : g_half
      logic signed [17:0] xa;
      logic signed [17:0] xb;
      logic signed [17:0] r;
      logic               ua;
      logic               ub;
      logic [15:0]        s;
      logic               q;
      assign ua = lanes.half_unsigned ? 1'h0 : lanes.a[16*i+15];
      assign ub = lanes.half_unsigned ? 1'h0 : lanes.b[16*i+15];
      assign xa = {ua, ua, lanes.a[16*i +: 16]};
      assign xb = {ub, ub, lanes.b[16*i +: 16]};
      assign r  = lanes.half_sub[i] ? xa - xb : xa + xb;
      // each half keeps its own process variables, so no two processes
      // share one vector
      always_comb
      begin
        q = 1'h0;
        s = r[15:0];
        if (lanes.half_unsigned)
        begin
          if (r > 18'sh0FFFF)
          begin
            q = 1'h1;
            s = 16'hFFFF;
          end
          else if (r < 18'sh00000)
          begin
            q = 1'h1;
            s = 16'h0000;
          end
        end
        else if (r > 18'sh07FFF)
        begin
          q = 1'h1;
          s = 16'h7FFF;
        end
        else if (r < -18'sh08000)
        begin
          q = 1'h1;
          s = 16'h8000;
        end
      end
      assign half_sum[16*i +: 16] = s;
      assign half_sat[i]          = q;
    end
  endgenerate

  logic signed [32:0] wa;
  logic signed [32:0] wb;
  logic signed [32:0] wr;
  assign wa = {lanes.a[31], lanes.a};
  assign wb = {lanes.b[31], lanes.b};
  assign wr = lanes.sub ? wa - wb : wa + wb;
  assign word_sat = wr[32] != wr[31];
  assign word_sum = !word_sat ? wr[31:0] :
                    (wr[32] ? 32'h8000_0000 : 32'h7FFF_FFFF);

  // ************************************************************
  // lane width select
  // ************************************************************
  // one, two or four lanes
  always_comb
  begin
    lanes.sum     = word_sum;
    lanes.sat_any = word_sat;
    case (lanes.width)
      sat_pkg::lane_half:
      begin
        lanes.sum     = half_sum;
        lanes.sat_any = |half_sat;
      end
      sat_pkg::lane_byte:
      begin
        lanes.sum     = byte_sum;
        lanes.sat_any = |byte_sat;
      end
      default:
      begin
        lanes.sum     = word_sum;
        lanes.sat_any = word_sat;
      end
    endcase
  end

endmodule

// >>> src/sat_pkg.sv
package sat_pkg;

  // ************************************************************
  // widths
  // ************************************************************
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic        STICKY_RST = 1'h0;
  localparam logic        VALID_RST  = 1'h0;
  localparam logic        CC_WE_RST  = 1'h0;

  // ************************************************************
  // operation set
  // ************************************************************
  typedef enum logic [3:0] {
    signed_word_clamp,
    unsigned_word_clamp,
    signed_dual_half_clamp,
    unsigned_dual_half_clamp,
    signed_sat_add,
    signed_sat_subtract,
    signed_sat_add_bytes,
    signed_sat_subtract_bytes,
    signed_sat_add_halves,
    signed_sat_subtract_halves,
    signed_add_sub_exchange,
    signed_sub_add_exchange,
    sat_double_then_add,
    sat_double_then_subtract,
    unsigned_add_sub_exchange,
    unsigned_sub_add_exchange
  } op_t;

  typedef enum logic {
    logical_shift_left,
    arith_shift_right
  } shift_kind_t;

  typedef enum logic [1:0] {
    lane_word,
    lane_half,
    lane_byte
  } lane_width_t;

endpackage

// >>> src/saturating_arith_unit.sv
`timescale 1ns/1ps


module saturating_arith_unit
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // operation request from decoder
  input  wire logic                 op_valid,
  input  wire sat_pkg::op_t         op_code,
  input  wire logic                 cond_pass,
  input  wire logic [31:0]          operand_a,
  input  wire logic [31:0]          operand_b,
  input  wire logic [5:0]           sat_pos,
  input  wire sat_pkg::shift_kind_t shift_kind,
  input  wire logic [4:0]           shift_amt,
  // status word access
  input  wire logic                 status_write,
  input  wire logic                 status_write_q,
  // results
  output logic [31:0]               result_reg,
  output logic                      result_valid_reg,
  output logic                      sticky_sat_reg,
  output logic                      cc_flags_we_reg
);

  // ************************************************************
  // clamp helper
  // ************************************************************
  // returns {saturated, value}; n outside the legal range gives
  // an undefined clamp, the decoder keeps n legal
  function automatic logic [32:0] clamp_val
  (
    input logic signed [32:0] v,
    input logic [5:0]         n,
    input logic               is_signed
  );
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    logic signed [33:0] x;
    logic [31:0]        r;
    logic               f;
    x = {v[32], v};
    if (is_signed)
    begin
      hi = (34'sh1 <<< (n - 6'h1)) - 34'sh1;
      lo = -(34'sh1 <<< (n - 6'h1));
    end
    else
    begin
      hi = (34'sh1 <<< n) - 34'sh1;
      lo = 34'sh0;
    end
    f = 1'h1;
    if (x > hi)
    begin
      r = hi[31:0];
    end
    else if (x < lo)
    begin
      r = lo[31:0];
    end
    else
    begin
      r = x[31:0];
      f = 1'h0;
    end
    return {f, r};
  endfunction

  // ************************************************************
  // word clamp path
  // ************************************************************
  logic [31:0] shifted;
  logic [32:0] word_clamp;
  logic        word_signed;

  assign shifted = (shift_kind == sat_pkg::arith_shift_right) ?
                   32'($signed(operand_b) >>> shift_amt) :
                   (operand_b << shift_amt);

  assign word_signed = (op_code == sat_pkg::signed_word_clamp);

  assign word_clamp = clamp_val({shifted[31], shifted}, sat_pos,
                                word_signed);

  // ************************************************************
  // dual half clamp path
  // ************************************************************
  logic [31:0] half_clamp;
  logic [1:0]  half_clamp_sat;
  logic        half_signed;

  assign half_signed = (op_code == sat_pkg::signed_dual_half_clamp);

  genvar h;
  generate
    for (h = 0; h < 2; h++)
    begin : g_half_clamp
      logic [32:0] c;
      logic [15:0] src;
      assign src = operand_b[16*h +: 16];
      assign c = clamp_val({{17{src[15]}}, src}, sat_pos, half_signed);
      assign half_clamp[16*h +: 16] = c[15:0];
      assign half_clamp_sat[h] = c[32];
    end
  endgenerate

  // ************************************************************
  // doubling step
  // ************************************************************
  logic [32:0] doubled;

  assign doubled = clamp_val({operand_b, 1'h0}, 6'h20, 1'h1);

  // ************************************************************
  // lane adder
  // ************************************************************
  addsub_if lanes ();

  lane_sat_addsub u_lanes
  (
    .lanes (lanes.unit)
  );

  always_comb
  begin
    lanes.a             = operand_a;
    lanes.b             = operand_b;
    lanes.sub           = 1'h0;
    lanes.half_sub      = 2'h0;
    lanes.half_unsigned = 1'h0;
    lanes.width         = sat_pkg::lane_word;
    case (op_code)
      sat_pkg::signed_sat_subtract:
        lanes.sub = 1'h1;
      sat_pkg::signed_sat_add_bytes:
        lanes.width = sat_pkg::lane_byte;
      sat_pkg::signed_sat_subtract_bytes:
      begin
        lanes.width = sat_pkg::lane_byte;
        lanes.sub   = 1'h1;
      end
      sat_pkg::signed_sat_add_halves:
        lanes.width = sat_pkg::lane_half;
      sat_pkg::signed_sat_subtract_halves:
      begin
        lanes.width    = sat_pkg::lane_half;
        lanes.half_sub = 2'h3;
      end
      sat_pkg::signed_add_sub_exchange,
      sat_pkg::unsigned_add_sub_exchange:
      begin
        lanes.width         = sat_pkg::lane_half;
        lanes.b             = {operand_b[15:0], operand_b[31:16]};
        lanes.half_sub      = 2'h1;
        lanes.half_unsigned = (op_code ==
                               sat_pkg::unsigned_add_sub_exchange);
      end
      sat_pkg::signed_sub_add_exchange,
      sat_pkg::unsigned_sub_add_exchange:
      begin
        lanes.width         = sat_pkg::lane_half;
        lanes.b             = {operand_b[15:0], operand_b[31:16]};
        lanes.half_sub      = 2'h2;
        lanes.half_unsigned = (op_code ==
                               sat_pkg::unsigned_sub_add_exchange);
      end
      sat_pkg::sat_double_then_add:
        lanes.b = doubled[31:0];
      sat_pkg::sat_double_then_subtract:
      begin
        lanes.b   = doubled[31:0];
        lanes.sub = 1'h1;
      end
      default:
      begin
        lanes.sub = 1'h0;
      end
    endcase
  end

  // ************************************************************
  // result and flag selection
  // ************************************************************
  logic [31:0] op_result;
  logic        op_sat;

  always_comb
  begin
    op_result = lanes.sum;
    op_sat    = 1'h0;
    case (op_code)
      sat_pkg::signed_word_clamp,
      sat_pkg::unsigned_word_clamp:
      begin
        op_result = word_clamp[31:0];
        op_sat    = word_clamp[32];
      end
      sat_pkg::signed_dual_half_clamp,
      sat_pkg::unsigned_dual_half_clamp:
      begin
        op_result = half_clamp;
        op_sat    = |half_clamp_sat;
      end
      sat_pkg::signed_sat_add,
      sat_pkg::signed_sat_subtract:
        op_sat = lanes.sat_any;
      sat_pkg::sat_double_then_add,
      sat_pkg::sat_double_then_subtract:
        op_sat = lanes.sat_any | doubled[32];
      default:
        op_sat = 1'h0;
    endcase
  end

  // ************************************************************
  // state update
  // ************************************************************
  logic [31:0] result_next;
  logic        result_valid_next;
  logic        sticky_sat_next;
  logic        cc_flags_we_next;
  logic        fire;

  assign fire = op_valid & cond_pass;

  always_comb
  begin
    result_next       = result_reg;
    result_valid_next = fire;
    sticky_sat_next   = sticky_sat_reg;
    cc_flags_we_next  = sat_pkg::CC_WE_RST;
    if (fire)
    begin
      result_next = op_result;
    end
    if (status_write)
    begin
      sticky_sat_next = status_write_q;
    end
    // saturation sets, and wins over a clear
    if (fire && op_sat)
    begin
      sticky_sat_next = 1'h1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      result_reg       <= sat_pkg::RESULT_RST;
      result_valid_reg <= sat_pkg::VALID_RST;
      sticky_sat_reg   <= sat_pkg::STICKY_RST;
      cc_flags_we_reg  <= sat_pkg::CC_WE_RST;
    end
    else
    begin
      result_reg       <= result_next;
      result_valid_reg <= result_valid_next;
      sticky_sat_reg   <= sticky_sat_next;
      cc_flags_we_reg  <= cc_flags_we_next;
    end
  end

endmodule

// >>> verification/sat_decoder_model.sv
`timescale 1ns/1ps

module sat_decoder_model
(
  // clock
  input  wire logic           core_clk,
  // requests to the unit
  output logic                op_valid,
  output sat_pkg::op_t        op_code,
  output logic                cond_pass,
  output logic [31:0]         operand_a,
  output logic [31:0]         operand_b,
  output logic [5:0]          sat_pos,
  output sat_pkg::shift_kind_t shift_kind,
  output logic [4:0]          shift_amt,
  output logic                status_write,
  output logic                status_write_q
);
  logic [31:0] exp_r[$];
  logic        exp_s[$];
  logic        sticky_m;

  initial
  begin
    op_valid = 1'h0;
    op_code = sat_pkg::signed_word_clamp;
    cond_pass = 1'h0;
    operand_a = 32'h0;
    operand_b = 32'h0;
    sat_pos = 6'h1;
    shift_kind = sat_pkg::logical_shift_left;
    shift_amt = 5'h0;
    status_write = 1'h0;
    status_write_q = 1'h0;
    sticky_m = 1'h0;
  end

  // ****************
  // reference arithmetic
  // ****************
  function automatic longint ext(input logic [31:0] x, input int s,
                                 input int w, input logic u);
    longint y;
    y = longint'(x >> s) & ((64'sh1 <<< w) - 1);
    if (!u && y[w - 1])
      y = y - (64'sh1 <<< w);
    return y;
  endfunction

  function automatic longint clamp(input longint v, input int n,
                                   input logic u);
    longint hi;
    longint lo;
    hi = u ? (64'sh1 <<< n) - 1 : (64'sh1 <<< (n - 1)) - 1;
    lo = u ? 64'sh0 : -(64'sh1 <<< (n - 1));
    return v > hi ? hi : (v < lo ? lo : v);
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] a,
    input logic [31:0] b, input int w, input logic [3:0] m, input logic u);
    logic [31:0] r;
    longint      c;
    r = 32'h0;
    for (int i = 0; i < 32 / w; i++)
    begin
      c = m[i] ? ext(a, i * w, w, u) - ext(b, i * w, w, u)
               : ext(a, i * w, w, u) + ext(b, i * w, w, u);
      r = r | ((32'(clamp(c, w, u)) & 32'((64'sh1 <<< w) - 1)) << (i * w));
    end
    return r;
  endfunction

  // ****************
  // requests
  // ****************
  task automatic issue(input sat_pkg::op_t op, input logic [31:0] a,
    input logic [31:0] b, input logic [31:0] rn, input logic cp,
    input logic clr = 1'h0);
    logic [31:0] r;
    logic [31:0] bs;
    longint      v;
    longint      c;
    longint      d;
    logic        sat;
    int          n;
    sat = 1'h0;
    r = 32'h0;
    @(negedge core_clk);
    shift_kind = sat_pkg::shift_kind_t'(rn[11]);
    shift_amt = rn[11] ? 5'(1 + rn[10:6] % 31) : rn[10:6];
    case (op)
      sat_pkg::signed_word_clamp: n = 1 + rn[4:0];
      sat_pkg::unsigned_word_clamp: n = rn[4:0];
      sat_pkg::signed_dual_half_clamp: n = 1 + rn[3:0];
      default: n = rn[3:0];
    endcase
    sat_pos = 6'(n);
    if (rn[11])
      bs = $signed(b) >>> shift_amt;
    else
      bs = b << shift_amt;
    v = ext(bs, 0, 32, 1'h0);
    case (op)
      sat_pkg::signed_word_clamp, sat_pkg::unsigned_word_clamp:
      begin
        c = clamp(v, n, op == sat_pkg::unsigned_word_clamp);
        r = 32'(c);
        sat = c != v;
      end
      sat_pkg::signed_dual_half_clamp, sat_pkg::unsigned_dual_half_clamp:
        for (int i = 0; i < 2; i++)
        begin
          v = ext(b, 16 * i, 16, 1'h0);
          c = clamp(v, n, op == sat_pkg::unsigned_dual_half_clamp);
          r[16 * i +: 16] = 16'(c);
          sat = sat | (c != v);
        end
      sat_pkg::signed_sat_add, sat_pkg::signed_sat_subtract,
      sat_pkg::sat_double_then_add, sat_pkg::sat_double_then_subtract:
      begin
        d = ext(b, 0, 32, 1'h0);
        if (op >= sat_pkg::sat_double_then_add)
        begin
          c = clamp(2 * d, 32, 1'h0);
          sat = c != 2 * d;
          d = c;
        end
        if (op == sat_pkg::signed_sat_subtract ||
            op == sat_pkg::sat_double_then_subtract)
          d = -d;
        v = ext(a, 0, 32, 1'h0) + d;
        c = clamp(v, 32, 1'h0);
        r = 32'(c);
        sat = sat | (c != v);
      end
      sat_pkg::signed_sat_add_bytes: r = lanes(a, b, 8, 4'h0, 1'h0);
      sat_pkg::signed_sat_subtract_bytes: r = lanes(a, b, 8, 4'hF, 1'h0);
      sat_pkg::signed_sat_add_halves: r = lanes(a, b, 16, 4'h0, 1'h0);
      sat_pkg::signed_sat_subtract_halves: r = lanes(a, b, 16, 4'h3, 1'h0);
      sat_pkg::signed_add_sub_exchange:
        r = lanes(a, {b[15:0], b[31:16]}, 16, 4'h1, 1'h0);
      sat_pkg::signed_sub_add_exchange:
        r = lanes(a, {b[15:0], b[31:16]}, 16, 4'h2, 1'h0);
      sat_pkg::unsigned_add_sub_exchange:
        r = lanes(a, {b[15:0], b[31:16]}, 16, 4'h1, 1'h1);
      default:
        r = lanes(a, {b[15:0], b[31:16]}, 16, 4'h2, 1'h1);
    endcase
    // operands arrive as values, never as stack or program counter
    op_valid = 1'h1;
    op_code = op;
    cond_pass = cp;
    operand_a = a;
    operand_b = b;
    // a status write in the same cycle clears before the set
    status_write = clr;
    status_write_q = 1'h0;
    if (clr)
      sticky_m = 1'h0;
    // flag only accumulates on a passed condition
    if (cp)
    begin
      sticky_m = sticky_m | sat;
      exp_r.push_back(r);
      exp_s.push_back(sticky_m);
    end
  endtask

  // write the flag through the status word, zero by default
  task automatic sclr(input logic q = 1'h0);
    @(negedge core_clk);
    op_valid = 1'h0;
    status_write = 1'h1;
    status_write_q = q;
    sticky_m = q;
    @(negedge core_clk);
    status_write = 1'h0;
  endtask

  task automatic idle();
    @(negedge core_clk);
    op_valid = 1'h0;
  endtask
endmodule

// >>> verification/sat_unit_sva.sv
`timescale 1ns/1ps

module sat_unit_sva
(
  // clock and reset
  input wire logic         core_clk,
  input wire logic         sys_rst,
  // request side
  input wire logic         op_valid,
  input wire sat_pkg::op_t op_code,
  input wire logic         cond_pass,
  input wire logic         status_write,
  input wire logic         status_write_q,
  // results
  input wire logic [31:0]  result_reg,
  input wire logic         result_valid_reg,
  input wire logic         sticky_sat_reg,
  input wire logic         cc_flags_we_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  logic fire;
  logic lane_op;
  assign fire = op_valid && cond_pass;
  // lane and exchange forms that leave the sticky flag alone
  assign lane_op = (op_code >= sat_pkg::signed_sat_add_bytes &&
                    op_code <= sat_pkg::signed_sub_add_exchange) ||
                   op_code >= sat_pkg::unsigned_add_sub_exchange;

  // ****************
  // checks
  // ****************
  chk_fire_valid: assert property (fire |=> result_valid_reg)
    else $error("fired op gave no result");
  chk_skip_holds: assert property (!fire |=>
    !result_valid_reg && $stable(result_reg))
    else $error("result moved without a fired op");
  chk_cc_quiet: assert property (cc_flags_we_reg == 1'h0)
    else $error("condition flags written");
  chk_sticky_keeps: assert property (
    sticky_sat_reg && !status_write |=> sticky_sat_reg)
    else $error("sticky flag cleared by the unit");
  chk_sticky_clear: assert property (
    status_write && !status_write_q && !fire |=> !sticky_sat_reg)
    else $error("status write did not clear sticky flag");
  chk_sticky_cause: assert property ($rose(sticky_sat_reg) |->
    $past(fire || (status_write && status_write_q)))
    else $error("sticky flag rose without cause");
  chk_lane_quiet: assert property (
    fire && lane_op && !status_write |=> $stable(sticky_sat_reg))
    else $error("lane form changed sticky flag");
  chk_uword_bound: assert property (result_valid_reg &&
    $past(op_code) == sat_pkg::unsigned_word_clamp |-> !result_reg[31])
    else $error("unsigned word clamp result negative");
  chk_uhalf_bound: assert property (result_valid_reg &&
    $past(op_code) == sat_pkg::unsigned_dual_half_clamp
    |-> !result_reg[31] && !result_reg[15])
    else $error("unsigned half clamp result too large");

  cov_sat_set: cover property (fire ##1 $rose(sticky_sat_reg));
  cov_clear: cover property (status_write && sticky_sat_reg);
  cov_refused: cover property (op_valid && !cond_pass);
endmodule

// >>> verification/saturating_arith_unit_tb_top.sv
`timescale 1ns/1ps

module saturating_arith_unit_tb_top;
  logic                 core_clk;
  logic                 sys_rst;
  logic                 op_valid, cond_pass, status_write, status_write_q;
  sat_pkg::op_t         op_code;
  logic [31:0]          operand_a, operand_b, result_reg;
  logic [5:0]           sat_pos;
  sat_pkg::shift_kind_t shift_kind;
  logic [4:0]           shift_amt;
  logic                 result_valid_reg, sticky_sat_reg, cc_flags_we_reg;
  int                   n_fail;
  int                   checks;

  sat_decoder_model dec(.core_clk(core_clk), .op_valid(op_valid),
    .op_code(op_code), .cond_pass(cond_pass), .operand_a(operand_a),
    .operand_b(operand_b), .sat_pos(sat_pos), .shift_kind(shift_kind),
    .shift_amt(shift_amt), .status_write(status_write),
    .status_write_q(status_write_q));

  saturating_arith_unit dut(.core_clk(core_clk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_code(op_code), .cond_pass(cond_pass),
    .operand_a(operand_a), .operand_b(operand_b), .sat_pos(sat_pos),
    .shift_kind(shift_kind), .shift_amt(shift_amt),
    .status_write(status_write), .status_write_q(status_write_q),
    .result_reg(result_reg), .result_valid_reg(result_valid_reg),
    .sticky_sat_reg(sticky_sat_reg), .cc_flags_we_reg(cc_flags_we_reg));

  always #5 core_clk = ~core_clk;

  task automatic cmp32(input string what, input logic [31:0] e,
                       input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic cmp1(input string what, input logic e, input logic s);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watcher: oldest note against each result, after the edge settles
  always @(posedge core_clk)
  begin
    #1;
    if (sys_rst === 1'h0 && result_valid_reg !== 1'h0)
    begin
      if (dec.exp_r.size() == 0)
        cmp1("unexpected result", 1'h0, result_valid_reg);
      else
      begin
        cmp32("result", dec.exp_r.pop_front(), result_reg);
        cmp1("sticky", dec.exp_s.pop_front(), sticky_sat_reg);
        cmp1("cc write", 1'h0, cc_flags_we_reg);
      end
    end
  end

  initial
  begin
    core_clk = 1'h0;
    sys_rst = 1'h1;
    n_fail = 0;
    checks = 0;
    void'($urandom(78545));
    repeat (10) @(negedge core_clk);
    sys_rst = 1'h0;
    cmp32("reset result", 32'h0, result_reg);
    cmp1("reset sticky", 1'h0, sticky_sat_reg);
    // boundary positions and shifts, a refused op, a late second step
    dec.issue(sat_pkg::signed_word_clamp, 32'h0, 32'h8000_0000,
              32'h1F, 1'h1);
    dec.issue(sat_pkg::unsigned_word_clamp, 32'h0, 32'h8000_0000,
              32'hF9F, 1'h1);
    dec.issue(sat_pkg::sat_double_then_add, 32'h0, 32'h4000_0000,
              32'h0, 1'h0);
    dec.sclr();
    dec.issue(sat_pkg::sat_double_then_subtract, 32'h1, 32'hC000_0000,
              32'h0, 1'h1);
    // flag written to one, then a clear meeting a set, then a plain clear
    dec.sclr(1'h1);
    dec.issue(sat_pkg::signed_sat_add, 32'h1, 32'h1, 32'h0, 1'h1);
    dec.issue(sat_pkg::signed_sat_add, 32'h7FFF_FFFF, 32'h1, 32'h0, 1'h1,
              1'h1);
    dec.issue(sat_pkg::signed_sat_add, 32'h1, 32'h1, 32'h0, 1'h1,
              1'h1);
    // every code, back to back, random operands and conditions
    for (int k = 0; k < 16; k++)
    begin
      dec.sclr();
      repeat (24)
        dec.issue(sat_pkg::op_t'(k), $urandom, $urandom, $urandom,
                  $urandom_range(7, 0) != 0);
    end
    dec.idle();
    for (int i = 0; i < 20 && dec.exp_r.size() != 0; i++)
      @(posedge core_clk);
    cmp1("results drained", 1'h1, dec.exp_r.size() == 0);
    give_verdict();
  end
endmodule

bind saturating_arith_unit sat_unit_sva chk(.core_clk(core_clk),
  .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
  .cond_pass(cond_pass), .status_write(status_write),
  .status_write_q(status_write_q), .result_reg(result_reg),
  .result_valid_reg(result_valid_reg), .sticky_sat_reg(sticky_sat_reg),
  .cc_flags_we_reg(cc_flags_we_reg));
